//--- cbt_exec.sv
/*
  Execution of compare-zero branches, the if-then prefix and table
  branches, with the if-then block state kept here.
  Assumes the core offers instructions only while ready is high, supplies
  operand values in the same cycle, and answers each table read once.
*/
`timescale 1ns/10ps
`default_nettype none
module cbt_exec (
  input  wire logic                  sys_clk_i,     // Core clock, 50 MHz
  input  wire logic                  rst_i,         // Asynchronous reset, high
  input  wire cbt_pkg::cbt_issue_s   issue_i,       // Offered instruction
  input  wire logic [15:0]           tbl_rdata_i,   // Table entry read back
  input  wire logic                  tbl_rvalid_i,  // Table entry valid
  input  wire logic                  exc_entry_i,   // Exception taken
  input  wire logic                  exc_return_i,  // Exception return
  input  wire logic [7:0]            exc_itstate_i, // Block state unstacked
  output logic                       ready_o,       // Next instruction taken
  output cbt_pkg::cbt_exec_s         exec_o,        // Condition result per instruction
  output cbt_pkg::cbt_branch_s       branch_o,      // Branch request
  output cbt_pkg::cbt_tbl_req_s      tbl_req_o,     // Table read request
  output logic [7:0]                 itstate_o,     // Block state, to be stacked
  output logic                       misuse_o       // Misplaced instruction seen
);
  import cbt_pkg::*;

  //----------------------------------------------------------------
  // State
  //----------------------------------------------------------------
  cbt_state_e   state_ff,   nxt_state;
  logic         ready_ff,   nxt_ready;
  cbt_exec_s    exec_ff,    nxt_exec;
  cbt_branch_s  br_ff,      nxt_br;
  cbt_tbl_req_s tbl_ff,     nxt_tbl;
  logic [7:0]   it_ff,      nxt_it;
  logic         misuse_ff,  nxt_misuse;
  logic [31:0]  pc4_ff,     nxt_pc4;
  logic         half_ff,    nxt_half;

  // Decode signals
  logic        acc;
  logic [15:0] hw1;
  logic [15:0] hw2;
  logic        in_it;
  logic        last_slot;
  logic [3:0]  slot_cond;
  logic        is_cbz;
  logic        is_it;
  logic        is_breakpoint_instruction;
  logic        is_cps;
  logic        is_tb;
  logic        pass;
  logic [31:0] pc4;
  logic [31:0] cbz_off;
  logic [31:0] tb_base;
  logic [31:0] tb_off;

  //----------------------------------------------------------------
  // Decode of the offered instruction
  //----------------------------------------------------------------
  // Instruction classes and the slot condition
  always_comb begin
    acc       = issue_i.valid && ready_ff;
    hw1       = issue_i.instr[31:16];
    hw2       = issue_i.instr[15:0];
    in_it     = (it_ff[3:0] != 4'h0);
    last_slot = (it_ff[3:0] == IT_LAST_SLOT);
    // Outside a block every instruction runs unconditionally
    slot_cond = in_it ? it_ff[7:4] : COND_AL;
    is_cbz    = ((hw1 & CBZ_MASK) == CBZ_VAL);
    is_it     = (hw1[15:8] == IT_OPC) && (hw1[3:0] != 4'h0);
    is_breakpoint_instruction   = (hw1[15:8] == BREAKPOINT_INSTRUCTION_OPC);
    is_cps    = ((hw1 & CPS_MASK) == CPS_VAL);
    is_tb     = ((hw1 & TB_HW1_MASK) == TB_HW1_VAL) && ((hw2 & TB_HW2_MASK) == TB_HW2_VAL);
    pass      = cbt_cond_pass(slot_cond, issue_i.nzcv) || is_breakpoint_instruction;
    pc4       = issue_i.pc + PC_AHEAD;
    // Offset i:imm5:0 gives 0..126, so targets land 4..130 bytes ahead
    cbz_off   = {22'h0, hw1[CBZ_I_BIT], hw1[7:3], 1'b0, 3'h0} >> 3;
    tb_base   = (hw1[3:0] == REG_PC) ? pc4 : issue_i.rn_val;
    tb_off    = hw2[TB_HALF_BIT] ? {issue_i.rm_val[30:0], 1'b0} : issue_i.rm_val;
  end

  //----------------------------------------------------------------
  // Next-state logic
  //----------------------------------------------------------------
  // Exceptions first, then table completion, then new instructions
  always_comb begin
    nxt_state  = state_ff;
    nxt_ready  = ready_ff;
    nxt_exec   = '{valid: 1'b0, pass: 1'b0};
    nxt_br     = '{valid: 1'b0, target: br_ff.target};
    nxt_tbl    = '{valid: 1'b0, half: tbl_ff.half, addr: tbl_ff.addr};
    nxt_it     = it_ff;
    nxt_misuse = 1'b0;
    nxt_pc4    = pc4_ff;
    nxt_half   = half_ff;
    if (exc_entry_i) begin
      // Handler runs outside any block; current state is on itstate_o to stack
      nxt_it    = IT_EMPTY;
      nxt_state = CBT_IDLE;
      nxt_ready = 1'b1;
    end else if (exc_return_i) begin
      nxt_it    = exc_itstate_i;
    end else begin
      unique case (state_ff)
        CBT_WAIT: begin
          if (tbl_rvalid_i) begin
            // Forward branch from the byte after the instruction
            nxt_br.valid  = 1'b1;
            nxt_br.target = pc4_ff + (half_ff ? {15'h0, tbl_rdata_i, 1'b0}
                                              : {24'h0, tbl_rdata_i[7:0]});
            nxt_state     = CBT_IDLE;
            nxt_ready     = 1'b1;
          end
        end
        CBT_IDLE: begin
          if (acc) begin
            nxt_exec = '{valid: 1'b1, pass: pass};
            // Shift the mask one slot; the block ends after the last slot
            nxt_it = (it_ff[2:0] == 3'h0) ? IT_EMPTY : {it_ff[7:5], it_ff[3:0], 1'b0};
            if (is_it) begin
              if (in_it) begin
                nxt_misuse = 1'b1;
              end else begin
                nxt_it = hw1[7:0];
              end
            end
            if (is_cbz) begin
              nxt_misuse = in_it;
              // Branch on zero, or on non-zero for the second form
              if (pass && ((issue_i.rn_val == 32'h0) != hw1[CBZ_NZ_BIT])) begin
                nxt_br.valid  = 1'b1;
                nxt_br.target = pc4 + cbz_off;
              end
            end
            if (is_tb) begin
              nxt_misuse = (in_it && !last_slot) || (hw1[3:0] == REG_SP)
                           || (hw2[3:0] == REG_SP) || (hw2[3:0] == REG_PC);
              if (pass) begin
                nxt_tbl   = '{valid: 1'b1, half: hw2[TB_HALF_BIT], addr: tb_base + tb_off};
                nxt_pc4   = pc4;
                nxt_half  = hw2[TB_HALF_BIT];
                nxt_state = CBT_WAIT;
                nxt_ready = 1'b0;
              end
            end
            if ((is_cps || (issue_i.pc_write && !last_slot)) && in_it) begin
              nxt_misuse = 1'b1;
            end
          end
        end
        default: begin
          nxt_state = CBT_IDLE;
          nxt_ready = 1'b1;
        end
      endcase
    end
  end

  //----------------------------------------------------------------
  // Registers
  //----------------------------------------------------------------
  // No flag output exists: these instructions never write the flags
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff  <= CBT_IDLE;
      ready_ff  <= 1'b1;
      exec_ff   <= '0;
      br_ff     <= '0;
      tbl_ff    <= '0;
      it_ff     <= IT_EMPTY;
      misuse_ff <= 1'b0;
      pc4_ff    <= 32'h0;
      half_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      ready_ff  <= nxt_ready;
      exec_ff   <= nxt_exec;
      br_ff     <= nxt_br;
      tbl_ff    <= nxt_tbl;
      it_ff     <= nxt_it;
      misuse_ff <= nxt_misuse;
      pc4_ff    <= nxt_pc4;
      half_ff   <= nxt_half;
    end
  end

  // Outputs straight from registers
  assign ready_o   = ready_ff;
  assign exec_o    = exec_ff;
  assign branch_o  = br_ff;
  assign tbl_req_o = tbl_ff;
  assign itstate_o = it_ff;
  assign misuse_o  = misuse_ff;

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  logic plain_acc;
  assign plain_acc = acc && !exc_entry_i && !exc_return_i && state_ff == CBT_IDLE;

  sequence s_tb_issue;
    tbl_req_o.valid;
  endsequence
  sequence s_tb_answer;
    state_ff == CBT_WAIT && tbl_rvalid_i && !exc_entry_i && !exc_return_i;
  endsequence

  AST_CBZ_TAKEN: assert property (plain_acc && is_cbz && !in_it && !hw1[CBZ_NZ_BIT] && issue_i.rn_val == 32'h0
    |=> branch_o.valid && branch_o.target == $past(issue_i.pc) + 32'h4
        + $past({25'h0, hw1[CBZ_I_BIT], hw1[7:3], 1'b0}))
    else $error("zero test branch not taken to forward target");
  AST_BRANCH_IF_REGISTER_NONZERO_HELD: assert property (plain_acc && is_cbz && hw1[CBZ_NZ_BIT] && issue_i.rn_val == 32'h0
    |=> !branch_o.valid)
    else $error("non-zero test branched on zero register");
  AST_IT_LOAD: assert property (plain_acc && is_it && !in_it
    |=> itstate_o == $past(issue_i.instr[23:16]) && exec_o.valid)
    else $error("prefix did not load block state");
  AST_SLOT_COND: assert property (plain_acc && in_it && !is_breakpoint_instruction
    |=> exec_o.pass == cbt_cond_pass($past(it_ff[7:4]), $past(issue_i.nzcv)))
    else $error("slot condition misapplied");
  AST_BREAKPOINT_INSTRUCTION_RUNS: assert property (plain_acc && is_breakpoint_instruction |=> exec_o.valid && exec_o.pass)
    else $error("breakpoint suppressed in block");
  AST_EXC_ENTRY: assert property (exc_entry_i |=> itstate_o == IT_EMPTY && ready_o && !tbl_req_o.valid)
    else $error("exception entry left block state");
  AST_EXC_RETURN: assert property (exc_return_i && !exc_entry_i |=> itstate_o == $past(exc_itstate_i))
    else $error("block state not restored on return");
  AST_BLOCK_END: assert property (plain_acc && !is_it && it_ff[2:0] == 3'h0 |=> itstate_o == IT_EMPTY)
    else $error("block state survived its last slot");
  AST_TB_BASE_PC: assert property (plain_acc && is_tb && pass && hw1[3:0] == REG_PC && !hw2[TB_HALF_BIT]
    |=> tbl_req_o.addr == $past(issue_i.pc) + 32'h4 + $past(issue_i.rm_val))
    else $error("table start not after the instruction");
  AST_TB_STALL: assert property (s_tb_issue |-> !ready_o)
    else $error("accepting while table read pending");
  AST_TBH_TARGET: assert property (s_tb_answer ##0 half_ff
    |=> branch_o.valid && ready_o
        && branch_o.target == $past(pc4_ff) + {15'h0, $past(tbl_rdata_i), 1'b0})
    else $error("halfword table target wrong");
endmodule
`default_nettype wire

//--- cbt_pkg.sv
/*
  Constants, carrier structs and a helper function for the compare-branch,
  if-then and table-branch execution block.
  Assumes a core that hands over one instruction at a time, with register
  operands already read, and a data port that returns table entries.
*/
`default_nettype none
package cbt_pkg;
  //----------------------------------------------------------------
  // Encodings and constants
  //----------------------------------------------------------------
  localparam logic [3:0]  COND_AL      = 4'hE;       // Always-true condition code
  localparam logic [3:0]  REG_SP       = 4'hD;       // Stack pointer number
  localparam logic [3:0]  REG_PC       = 4'hF;       // Program counter number
  localparam logic [31:0] PC_AHEAD     = 32'h0000_0004; // Read value of PC is address plus 4
  localparam logic [7:0]  IT_EMPTY     = 8'h00;      // No block in progress
  localparam logic [3:0]  IT_LAST_SLOT = 4'h8;       // Low bits when one slot is left
  localparam logic [15:0] CBZ_MASK     = 16'hF500;   // Compare-zero branch opcode mask
  localparam logic [15:0] CBZ_VAL      = 16'hB100;   // Compare-zero branch opcode value
  localparam int          CBZ_NZ_BIT   = 11;         // Set for the non-zero form
  localparam int          CBZ_I_BIT    = 9;          // Top offset bit position
  localparam logic [7:0]  IT_OPC       = 8'hBF;      // If-then prefix opcode byte
  localparam logic [7:0]  BREAKPOINT_INSTRUCTION_OPC     = 8'hBE;      // Breakpoint opcode byte
  localparam logic [15:0] CPS_MASK     = 16'hFFEF;   // Interrupt mask change opcode mask
  localparam logic [15:0] CPS_VAL      = 16'hB662;   // Interrupt mask change opcode value
  localparam logic [15:0] TB_HW1_MASK  = 16'hFFF0;   // Table branch first halfword mask
  localparam logic [15:0] TB_HW1_VAL   = 16'hE8D0;   // Table branch first halfword value
  localparam logic [15:0] TB_HW2_MASK  = 16'hFFE0;   // Table branch second halfword mask
  localparam logic [15:0] TB_HW2_VAL   = 16'hF000;   // Table branch second halfword value
  localparam int          TB_HALF_BIT  = 4;          // Set for halfword tables

  //----------------------------------------------------------------
  // Types
  //----------------------------------------------------------------
  typedef enum logic [1:0] {CBT_IDLE = 2'b01, CBT_WAIT = 2'b10} cbt_state_e;

  typedef struct packed {
    logic        valid;     // Instruction offered
    logic [31:0] instr;     // First halfword in [31:16]
    logic [31:0] pc;        // Address of the instruction
    logic [31:0] rn_val;    // Value of the first register field
    logic [31:0] rm_val;    // Value of the index register field
    logic [3:0]  nzcv;      // Current condition flags
    logic        pc_write;  // Other instruction that writes the PC
  } cbt_issue_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] target;
  } cbt_branch_s;

  typedef struct packed {
    logic        valid;
    logic        half;
    logic [31:0] addr;
  } cbt_tbl_req_s;

  typedef struct packed {
    logic valid;
    logic pass;
  } cbt_exec_s;

  // Condition check against N Z C V
  function automatic logic cbt_cond_pass(input logic [3:0] cond, input logic [3:0] f);
    logic r;
    r = 1'b1;
    unique case (cond[3:1])
      3'h0: r = f[2];
      3'h1: r = f[1];
      3'h2: r = f[3];
      3'h3: r = f[0];
      3'h4: r = f[1] & ~f[2];
      3'h5: r = (f[3] == f[0]);
      3'h6: r = ~f[2] & (f[3] == f[0]);
      3'h7: r = 1'b1;
    endcase
    return (cond[0] && cond != 4'hF) ? ~r : r;
  endfunction
endpackage
`default_nettype wire

//--- tb.sv
/*
  Self-checking bench for the compare-branch, if-then and table-branch block.
  Assumes the cbt_pkg package and the cbt_exec module are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cbt_pkg::*;
  logic        sys_clk_i;
  logic        rst_i;
  cbt_issue_s  issue_i;
  logic [15:0] tbl_rdata_i;
  logic        tbl_rvalid_i;
  logic        exc_entry_i;
  logic        exc_return_i;
  logic [7:0]  exc_itstate_i;
  logic        ready_o;
  cbt_exec_s   exec_o;
  cbt_branch_s branch_o;
  cbt_tbl_req_s tbl_req_o;
  logic [7:0]  itstate_o;
  logic        misuse_o;
  int          failures;
  int          checks;
  logic [31:0] seed;
  logic [31:0] r;
  logic [7:0]  mdl_it;
  logic [7:0]  saved;
  logic        pcw;
  localparam logic [31:0] PLAIN = 32'h4608_0000; // Register move, no side effects

  cbt_exec uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .issue_i(issue_i), .tbl_rdata_i(tbl_rdata_i),
    .tbl_rvalid_i(tbl_rvalid_i), .exc_entry_i(exc_entry_i), .exc_return_i(exc_return_i),
    .exc_itstate_i(exc_itstate_i), .ready_o(ready_o), .exec_o(exec_o), .branch_o(branch_o),
    .tbl_req_o(tbl_req_o), .itstate_o(itstate_o), .misuse_o(misuse_o));

  // ------------------------------------------------------------
  // Helpers: random source, condition model, compare, verdict
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    logic v;
    case (c[3:1])
      3'h0: v = f[2];
      3'h1: v = f[1];
      3'h2: v = f[3];
      3'h3: v = f[0];
      3'h4: v = f[1] & ~f[2];
      3'h5: v = (f[3] == f[0]);
      3'h6: v = ~f[2] & (f[3] == f[0]);
      default: v = 1'b1;
    endcase
    return (c[0] && c != 4'hF) ? ~v : v;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Offers one instruction and compares its answers with the model; branch and table outputs only for those instructions
  task automatic run(input logic [31:0] ins, input logic [31:0] rn, input logic [3:0] nz, input logic mis);
    logic [31:0] pc, rm, base, d;
    logic        inb, pass, tk;
    int          n;
    pc = rnd() & 32'h00FF_FFFE;
    rm = rnd() & 32'h0000_00FF;
    issue_i <= '{1'b1, ins, pc, rn, rm, nz, pcw};
    inb = (mdl_it != 8'h00);
    pass = !inb || cond_ok(mdl_it[7:4], nz) || ins[31:24] == 8'hBE;
    if (inb)
      mdl_it = (mdl_it[2:0] == 3'h0) ? 8'h00 : {mdl_it[7:5], mdl_it[3:0], 1'b0};
    else if (ins[31:24] == 8'hBF && ins[19:16] != 4'h0)
      mdl_it = ins[23:16];
    @(negedge sys_clk_i);
    chk({31'h0, exec_o.valid}, 32'h1);
    chk({31'h0, exec_o.pass}, {31'h0, pass});
    chk({24'h0, itstate_o}, {24'h0, mdl_it});
    chk({31'h0, misuse_o}, {31'h0, mis});
    if ((ins[31:16] & 16'hF500) == 16'hB100) begin
      tk = pass && ((rn == 32'h0) != ins[27]);
      chk({31'h0, branch_o.valid}, {31'h0, tk});
      if (tk)
        chk(branch_o.target, pc + 32'h4 + {25'h0, ins[25], ins[23:19], 1'b0});
    end
    if ((ins[31:16] & 16'hFFF0) == 16'hE8D0 && pass) begin
      base = (ins[19:16] == 4'hF) ? pc + 32'h4 : rn;
      chk({31'h0, tbl_req_o.valid}, 32'h1);
      chk({31'h0, tbl_req_o.half}, {31'h0, ins[4]});
      chk(tbl_req_o.addr, base + (ins[4] ? rm << 1 : rm));
      chk({31'h0, ready_o}, 32'h0);
      issue_i.valid <= 1'b0;
      d = rnd();
      tbl_rdata_i <= d[15:0];
      tbl_rvalid_i <= 1'b1;
      @(negedge sys_clk_i);
      tbl_rvalid_i <= 1'b0;
      n = 0;
      while (branch_o.valid !== 1'b1 && n < 4) begin
        @(negedge sys_clk_i);
        n++;
      end
      chk({31'h0, branch_o.valid}, 32'h1);
      chk(branch_o.target, pc + 32'h4 + (ins[4] ? {15'h0, d[15:0], 1'b0} : {24'h0, d[7:0]}));
      chk({31'h0, ready_o}, 32'h1);
    end
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // Whole run needs far fewer than 10000 cycles
  initial begin
    #200000;
    failures++;
    end_sim();
  end

  initial begin
    failures = 0;
    checks = 0;
    seed = 32'h0001_4045;
    mdl_it = 8'h00;
    pcw = 1'b0;
    rst_i = 1'b1;
    issue_i = '0;
    tbl_rdata_i = 16'h0000;
    tbl_rvalid_i = 1'b0;
    exc_entry_i = 1'b0;
    exc_return_i = 1'b0;
    exc_itstate_i = 8'h00;
    repeat (10) @(negedge sys_clk_i);
    rst_i <= 1'b0;
    chk({31'h0, ready_o}, 32'h1);
    chk({24'h0, itstate_o}, 32'h0);
    // Random mix of zero tests, prefixes, tables, breakpoints and plain code
    repeat (80) begin
      r = rnd();
      if (mdl_it == 8'h00 && r[31:30] == 2'h0)
        run({16'hB100 | {4'h0, r[11], 1'b0, r[9], 9'h0} | {8'h0, r[7:3], r[2:0]}, 16'h0},
            r[12] ? 32'h0 : rnd(), r[23:20], 1'b0);
      else if (mdl_it == 8'h00 && r[31:30] == 2'h1)
        run({8'hBF, (r[3:0] == 4'hF) ? 4'hE : r[3:0],
             (r[3:0] >= 4'hE) ? 4'h8 >> r[5:4] : ((r[7:4] == 4'h0) ? 4'h8 : r[7:4]), 16'h0},
            32'h0, r[23:20], 1'b0);
      else if (mdl_it == 8'h00 && r[31:30] == 2'h2)
        run({12'hE8D, (r[3:0] == 4'hD) ? 4'hF : r[3:0], 11'h780, r[4], 4'h1}, rnd() & 32'h0000_FFFF,
            r[23:20], 1'b0);
      else
        run(r[8] ? 32'hBE00_0000 : PLAIN, 32'h0, r[23:20], 1'b0);
    end
    while (mdl_it != 8'h00)
      run(PLAIN, 32'h0, 4'h0, 1'b0);
    // Exception inside a block, handler code, then return and finish the block
    run(32'hBF1F_0000, 32'h0, 4'h0, 1'b0);
    run(PLAIN, 32'h0, 4'h0, 1'b0);
    saved = mdl_it;
    issue_i <= '{1'b1, PLAIN, 32'h100, 32'h0, 32'h0, 4'h0, 1'b0};
    exc_entry_i <= 1'b1;
    @(negedge sys_clk_i);
    exc_entry_i <= 1'b0;
    chk({31'h0, exec_o.valid}, 32'h0);
    chk({24'h0, itstate_o}, 32'h0);
    mdl_it = 8'h00;
    run(PLAIN, 32'h0, 4'h4, 1'b0);
    issue_i.valid <= 1'b0;
    exc_itstate_i <= saved;
    exc_return_i <= 1'b1;
    @(negedge sys_clk_i);
    exc_return_i <= 1'b0;
    chk({24'h0, itstate_o}, {24'h0, saved});
    mdl_it = saved;
    run(32'hB100_0000, 32'h0, 4'h2, 1'b1);
    while (mdl_it != 8'h00)
      run(PLAIN, 32'h0, 4'h2, 1'b0);
    // Mask change and early counter writer in a three-slot block
    run(32'hBF02_0000, 32'h0, 4'h4, 1'b0);
    run(32'hB672_0000, 32'h0, 4'h4, 1'b1);
    pcw = 1'b1;
    run(PLAIN, 32'h0, 4'h4, 1'b1);
    run(PLAIN, 32'h0, 4'h4, 1'b0);
    pcw = 1'b0;
    // Table read aborted by an exception; the late answer is ignored
    issue_i <= '{1'b1, 32'hE8D1_F002, 32'h200, 32'h300, 32'h1, 4'h0, 1'b0};
    @(negedge sys_clk_i);
    issue_i.valid <= 1'b0;
    exc_entry_i <= 1'b1;
    @(negedge sys_clk_i);
    exc_entry_i <= 1'b0;
    tbl_rvalid_i <= 1'b1;
    @(negedge sys_clk_i);
    tbl_rvalid_i <= 1'b0;
    repeat (2) begin
      @(negedge sys_clk_i);
      chk({31'h0, branch_o.valid}, 32'h0);
    end
    chk({31'h0, ready_o}, 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire
